/* File: hdl/opcode_timing_pkg.sv */
package opcode_timing_pkg;

	typedef enum logic [3:0] {
		op_none,
		op_swap_operands,
		op_load_effective_offset,
		op_far_load_data_segment,
		op_far_load_extra_segment,
		op_far_load_third_segment,
		op_far_load_fourth_segment,
		op_far_load_stack_segment,
		op_carry_clear,
		op_interrupt_enable_clear,
		op_task_switched_clear,
		op_carry_invert,
		op_flags_to_acc_high
	} op_t;

	typedef enum logic [2:0] {
		seg_none,
		seg_data,
		seg_extra,
		seg_third_extra,
		seg_fourth_extra,
		seg_stack
	} seg_t;

	localparam int CYC_W = 5;

	// One-byte opcodes.
	localparam logic [4:0] SWAP_ACC_TOP = 5'h12;
	localparam logic [7:0] LOAD_EFF_OPC = 8'h8D;
	localparam logic [7:0] FAR_DATA_OPC = 8'hC5;
	localparam logic [7:0] FAR_EXTRA_OPC = 8'hC4;
	localparam logic [7:0] CARRY_CLEAR_OPC = 8'hF8;
	localparam logic [7:0] INT_CLEAR_OPC = 8'hFA;
	localparam logic [7:0] CARRY_INVERT_OPC = 8'hF5;
	localparam logic [7:0] FLAGS_HIGH_OPC = 8'h9F;
	localparam logic [7:0] ESCAPE_OPC = 8'h0F;

	// Second bytes after the escape byte.
	localparam logic [7:0] FAR_THIRD_OPC2 = 8'hB4;
	localparam logic [7:0] FAR_FOURTH_OPC2 = 8'hB5;
	localparam logic [7:0] FAR_STACK_OPC2 = 8'hB2;
	localparam logic [7:0] TS_CLEAR_OPC2 = 8'h06;

	// Operand selector byte fields.
	localparam int MODE_MSB = 7;
	localparam int MODE_LSB = 6;
	localparam int REG_MSB = 5;
	localparam int REG_LSB = 3;
	localparam int RM_MSB = 2;
	localparam int RM_LSB = 0;

	// Clock counts.
	localparam logic [CYC_W-1:0] CYC_SWAP = 5'h03;
	localparam logic [CYC_W-1:0] CYC_LOAD_EFF = 5'h02;
	localparam logic [CYC_W-1:0] CYC_FAR_REAL = 5'h07;
	localparam logic [CYC_W-1:0] CYC_FAR_PROT = 5'h1A;
	localparam logic [CYC_W-1:0] CYC_FAR_PROT_ALT = 5'h1C;
	localparam logic [CYC_W-1:0] CYC_FAR_THIRD_PROT = 5'h1D;
	localparam logic [CYC_W-1:0] CYC_FAR_THIRD_PROT_ALT = 5'h1F;
	localparam logic [CYC_W-1:0] CYC_CARRY = 5'h02;
	localparam logic [CYC_W-1:0] CYC_INT_CLEAR = 5'h08;
	localparam logic [CYC_W-1:0] CYC_TS_CLEAR = 5'h05;
	localparam logic [CYC_W-1:0] CYC_FLAGS_HIGH = 5'h02;

endpackage

/* File: hdl/op_cycle_timer.sv */
`timescale 1ns/1ps

module op_cycle_timer #(
	parameter int W = 5
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_load,
	input wire logic [W-1:0] i_count,
	output logic o_busy,
	output logic o_done
);

	logic [W-1:0] remain;
	logic busy;
	logic done;
	logic [W-1:0] next_remain;
	logic next_busy;
	logic next_done;

	// A zero count would wrap the counter into a run of 2^W cycles, so it is run as one cycle.
	always_comb begin
		next_remain = remain;
		next_busy = busy;
		next_done = 1'b0;
		if (i_load) begin
			next_remain = (i_count == '0) ? W'(1) : i_count;
			next_busy = 1'b1;
		end else if (busy) begin
			next_remain = remain - W'(1);
			next_busy = (remain != W'(1));
			next_done = (remain == W'(1));
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			remain <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			remain <= next_remain;
			busy <= next_busy;
			done <= next_done;
		end
	end

	assign o_busy = busy;
	assign o_done = done;

endmodule // op_cycle_timer

/* File: hdl/opcode_timing_decoder.sv */
// Overview of operation
// - Byte 10010 plus register code swaps register with accumulator, 3 clocks.
// - Opcode 10001101 with selector loads effective offset, 2 clocks always.
// - Opcode 11000101 far-loads register and data segment, 7 or 26/28 clocks.
// - Opcode 11000100 far-loads register and extra segment, 7 or 26/28 clocks.
// - Escaped 10110100 far-loads third extra segment, 7 or 29/31 clocks.
// - Escaped 10110101 far-loads fourth extra segment, 7 or 26/28 clocks.
// - Escaped 10110010 far-loads stack segment, 7 or 26/28 clocks.
// - Byte 11111000 clears carry flag in 2 clocks.
// - Byte 11111010 clears interrupt-enable flag in 8 clocks.
// - Escaped 00000110 clears task-switched flag in 5 clocks.
// - Byte 11110101 inverts carry flag in 2 clocks.
// - Byte 10011111 copies low flags to accumulator high byte, 2 clocks.
`timescale 1ns/1ps

module opcode_timing_decoder #(
	parameter int CW = opcode_timing_pkg::CYC_W
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_byte_valid,
	input wire logic [7:0] i_byte,
	input wire logic i_protected_mode,
	input wire logic i_alt_timing,
	output logic o_byte_ready,
	output opcode_timing_pkg::op_t o_op,
	output opcode_timing_pkg::seg_t o_seg,
	output logic [2:0] o_reg,
	output logic [1:0] o_mode,
	output logic [2:0] o_rm,
	output logic [CW-1:0] o_cycles,
	output logic o_busy,
	output logic o_done,
	output logic o_illegal,
	output logic o_carry_clear,
	output logic o_carry_invert,
	output logic o_int_enable_clear,
	output logic o_task_switched_clear,
	output logic o_flags_to_acc_high
);

	typedef enum logic [1:0] {
		st_opcode,
		st_escaped,
		st_selector,
		st_run
	} state_t;

	state_t state;
	state_t next_state;
	logic byte_ready;
	logic next_byte_ready;
	opcode_timing_pkg::op_t op;
	opcode_timing_pkg::op_t next_op;
	opcode_timing_pkg::seg_t seg;
	opcode_timing_pkg::seg_t next_seg;
	logic [2:0] reg_sel;
	logic [2:0] next_reg_sel;
	logic [1:0] mode;
	logic [1:0] next_mode;
	logic [2:0] rm;
	logic [2:0] next_rm;
	logic [CW-1:0] cycles;
	logic [CW-1:0] next_cycles;
	logic illegal;
	logic next_illegal;
	logic prot;
	logic next_prot;
	logic start;
	logic [CW-1:0] start_count;
	logic tmr_busy;
	logic tmr_done;
	logic carry_clear;
	logic carry_invert;
	logic int_clear;
	logic ts_clear;
	logic flags_high;
	logic next_carry_clear;
	logic next_carry_invert;
	logic next_int_clear;
	logic next_ts_clear;
	logic next_flags_high;
	logic take;
	logic start_seen;
	logic next_start_seen;

	// Clock count of an instruction, chosen from the operating mode that was
	// sampled with its first byte and the alternate-path input.
	function automatic logic [CW-1:0] cycles_for(
		input opcode_timing_pkg::op_t f_op,
		input logic f_prot,
		input logic f_alt
	);
		logic [CW-1:0] c;
		c = opcode_timing_pkg::CYC_CARRY;
		case (f_op)
			opcode_timing_pkg::op_swap_operands: begin
				c = opcode_timing_pkg::CYC_SWAP;
			end
			opcode_timing_pkg::op_load_effective_offset: begin
				c = opcode_timing_pkg::CYC_LOAD_EFF;
			end
			opcode_timing_pkg::op_far_load_data_segment,
			opcode_timing_pkg::op_far_load_extra_segment,
			opcode_timing_pkg::op_far_load_fourth_segment,
			opcode_timing_pkg::op_far_load_stack_segment: begin
				if (!f_prot) begin
					c = opcode_timing_pkg::CYC_FAR_REAL;
				end else if (f_alt) begin
					c = opcode_timing_pkg::CYC_FAR_PROT_ALT;
				end else begin
					c = opcode_timing_pkg::CYC_FAR_PROT;
				end
			end
			opcode_timing_pkg::op_far_load_third_segment: begin
				if (!f_prot) begin
					c = opcode_timing_pkg::CYC_FAR_REAL;
				end else if (f_alt) begin
					c = opcode_timing_pkg::CYC_FAR_THIRD_PROT_ALT;
				end else begin
					c = opcode_timing_pkg::CYC_FAR_THIRD_PROT;
				end
			end
			opcode_timing_pkg::op_carry_clear: begin
				c = opcode_timing_pkg::CYC_CARRY;
			end
			opcode_timing_pkg::op_interrupt_enable_clear: begin
				c = opcode_timing_pkg::CYC_INT_CLEAR;
			end
			opcode_timing_pkg::op_task_switched_clear: begin
				c = opcode_timing_pkg::CYC_TS_CLEAR;
			end
			opcode_timing_pkg::op_carry_invert: begin
				c = opcode_timing_pkg::CYC_CARRY;
			end
			opcode_timing_pkg::op_flags_to_acc_high: begin
				c = opcode_timing_pkg::CYC_FLAGS_HIGH;
			end
			default: begin
				c = opcode_timing_pkg::CYC_CARRY;
			end
		endcase
		return c;
	endfunction

	assign take = i_byte_valid && byte_ready;

	// Fetch and decode sequencer.
	always_comb begin
		next_state = state;
		next_op = op;
		next_seg = seg;
		next_reg_sel = reg_sel;
		next_mode = mode;
		next_rm = rm;
		next_cycles = cycles;
		next_prot = prot;
		next_illegal = 1'b0;
		start = 1'b0;
		start_count = cycles_for(op, prot, i_alt_timing);
		case (state)
			st_opcode: begin
				if (take) begin
					next_prot = i_protected_mode;
					next_reg_sel = 3'h0;
					next_mode = 2'h0;
					next_rm = 3'h0;
					next_seg = opcode_timing_pkg::seg_none;
					next_op = opcode_timing_pkg::op_none;
					next_state = st_run;
					if (i_byte[7:3] == opcode_timing_pkg::SWAP_ACC_TOP) begin
						next_op = opcode_timing_pkg::op_swap_operands;
						next_reg_sel = i_byte[2:0];
					end else if (i_byte == opcode_timing_pkg::LOAD_EFF_OPC) begin
						next_op = opcode_timing_pkg::op_load_effective_offset;
						next_state = st_selector;
					end else if (i_byte == opcode_timing_pkg::FAR_DATA_OPC) begin
						next_op = opcode_timing_pkg::op_far_load_data_segment;
						next_seg = opcode_timing_pkg::seg_data;
						next_state = st_selector;
					end else if (i_byte == opcode_timing_pkg::FAR_EXTRA_OPC) begin
						next_op = opcode_timing_pkg::op_far_load_extra_segment;
						next_seg = opcode_timing_pkg::seg_extra;
						next_state = st_selector;
					end else if (i_byte == opcode_timing_pkg::CARRY_CLEAR_OPC) begin
						next_op = opcode_timing_pkg::op_carry_clear;
					end else if (i_byte == opcode_timing_pkg::INT_CLEAR_OPC) begin
						next_op = opcode_timing_pkg::op_interrupt_enable_clear;
					end else if (i_byte == opcode_timing_pkg::CARRY_INVERT_OPC) begin
						next_op = opcode_timing_pkg::op_carry_invert;
					end else if (i_byte == opcode_timing_pkg::FLAGS_HIGH_OPC) begin
						next_op = opcode_timing_pkg::op_flags_to_acc_high;
					end else if (i_byte == opcode_timing_pkg::ESCAPE_OPC) begin
						next_state = st_escaped;
					end else begin
						// Bytes outside this slice are refused with a pulse.
						next_illegal = 1'b1;
						next_state = st_opcode;
					end
				end
			end
			st_escaped: begin
				if (take) begin
					next_state = st_selector;
					if (i_byte == opcode_timing_pkg::FAR_THIRD_OPC2) begin
						next_op = opcode_timing_pkg::op_far_load_third_segment;
						next_seg = opcode_timing_pkg::seg_third_extra;
					end else if (i_byte == opcode_timing_pkg::FAR_FOURTH_OPC2) begin
						next_op = opcode_timing_pkg::op_far_load_fourth_segment;
						next_seg = opcode_timing_pkg::seg_fourth_extra;
					end else if (i_byte == opcode_timing_pkg::FAR_STACK_OPC2) begin
						next_op = opcode_timing_pkg::op_far_load_stack_segment;
						next_seg = opcode_timing_pkg::seg_stack;
					end else if (i_byte == opcode_timing_pkg::TS_CLEAR_OPC2) begin
						next_op = opcode_timing_pkg::op_task_switched_clear;
						next_state = st_run;
					end else begin
						next_illegal = 1'b1;
						next_state = st_opcode;
					end
				end
			end
			st_selector: begin
				if (take) begin
					next_mode = i_byte[opcode_timing_pkg::MODE_MSB:
						opcode_timing_pkg::MODE_LSB];
					next_reg_sel = i_byte[opcode_timing_pkg::REG_MSB:
						opcode_timing_pkg::REG_LSB];
					next_rm = i_byte[opcode_timing_pkg::RM_MSB:
						opcode_timing_pkg::RM_LSB];
					next_state = st_run;
				end
			end
			st_run: begin
				// The count starts one cycle after the last byte, once the
				// alternate-path input for far loads has settled.
				if (!tmr_busy && !tmr_done && !start_seen) begin
					start = 1'b1;
					next_cycles = start_count;
				end else if (tmr_done) begin
					next_state = st_opcode;
				end
			end
			default: begin
				next_state = st_opcode;
			end
		endcase
	end

	always_comb begin
		next_start_seen = start_seen;
		if (state != st_run) begin
			next_start_seen = 1'b0;
		end else if (start) begin
			next_start_seen = 1'b1;
		end
	end

	// Flag actions are reported once, as the instruction completes.
	always_comb begin
		next_carry_clear = tmr_done && (op == opcode_timing_pkg::op_carry_clear);
		next_carry_invert = tmr_done && (op == opcode_timing_pkg::op_carry_invert);
		next_int_clear = tmr_done &&
			(op == opcode_timing_pkg::op_interrupt_enable_clear);
		next_ts_clear = tmr_done &&
			(op == opcode_timing_pkg::op_task_switched_clear);
		next_flags_high = tmr_done &&
			(op == opcode_timing_pkg::op_flags_to_acc_high);
		next_byte_ready = (next_state != st_run);
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= st_opcode;
			byte_ready <= 1'b0;
			op <= opcode_timing_pkg::op_none;
			seg <= opcode_timing_pkg::seg_none;
			reg_sel <= 3'h0;
			mode <= 2'h0;
			rm <= 3'h0;
			cycles <= '0;
			prot <= 1'b0;
			illegal <= 1'b0;
			start_seen <= 1'b0;
			carry_clear <= 1'b0;
			carry_invert <= 1'b0;
			int_clear <= 1'b0;
			ts_clear <= 1'b0;
			flags_high <= 1'b0;
		end else begin
			state <= next_state;
			byte_ready <= next_byte_ready;
			op <= next_op;
			seg <= next_seg;
			reg_sel <= next_reg_sel;
			mode <= next_mode;
			rm <= next_rm;
			cycles <= next_cycles;
			prot <= next_prot;
			illegal <= next_illegal;
			start_seen <= next_start_seen;
			carry_clear <= next_carry_clear;
			carry_invert <= next_carry_invert;
			int_clear <= next_int_clear;
			ts_clear <= next_ts_clear;
			flags_high <= next_flags_high;
		end
	end

	op_cycle_timer #(
		.W(CW)
	) u_timer (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_load(start),
		.i_count(start_count),
		.o_busy(tmr_busy),
		.o_done(tmr_done)
	);

	assign o_byte_ready = byte_ready;
	assign o_op = op;
	assign o_seg = seg;
	assign o_reg = reg_sel;
	assign o_mode = mode;
	assign o_rm = rm;
	assign o_cycles = cycles;
	assign o_busy = tmr_busy;
	assign o_done = tmr_done;
	assign o_illegal = illegal;
	assign o_carry_clear = carry_clear;
	assign o_carry_invert = carry_invert;
	assign o_int_enable_clear = int_clear;
	assign o_task_switched_clear = ts_clear;
	assign o_flags_to_acc_high = flags_high;

endmodule // opcode_timing_decoder

/* File: sim/opcode_timing_checker_props.sv */
`timescale 1ns/1ps

module opcode_timing_checker #(
	parameter int CW = opcode_timing_pkg::CYC_W
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic o_byte_ready,
	input wire opcode_timing_pkg::op_t o_op,
	input wire opcode_timing_pkg::seg_t o_seg,
	input wire logic [CW-1:0] o_cycles,
	input wire logic o_busy,
	input wire logic o_done,
	input wire logic o_illegal,
	input wire logic o_carry_clear,
	input wire logic o_int_enable_clear
);
	// Counting busy cycles here ties the run length to the reported count.
	logic [CW:0] busy_run;
	logic [CW:0] next_busy_run;
	always_comb begin
		next_busy_run = o_busy ? busy_run + 1'b1 : '0;
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_run <= '0;
		end else begin
			busy_run <= next_busy_run;
		end
	end
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);
	busy_length_a: assert property (
		$fell(o_busy) |-> o_done && busy_run == {1'b0, o_cycles})
		else $error("busy length differs from clock count");
	done_then_ready_a: assert property (
		o_done |=> !o_done ##0 o_byte_ready)
		else $error("done not a single pulse before ready");
	busy_refuse_a: assert property (
		o_busy |-> !o_byte_ready)
		else $error("ready while busy");
	swap_count_a: assert property (
		o_busy && o_op == opcode_timing_pkg::op_swap_operands |-> o_cycles == 3)
		else $error("swap count wrong");
	two_clock_a: assert property (
		o_busy && o_op inside {opcode_timing_pkg::op_carry_clear,
		opcode_timing_pkg::op_carry_invert, opcode_timing_pkg::op_flags_to_acc_high,
		opcode_timing_pkg::op_load_effective_offset} |-> o_cycles == 2)
		else $error("two clock count wrong");
	int_clear_count_a: assert property (
		o_busy && o_op == opcode_timing_pkg::op_interrupt_enable_clear
		|-> o_cycles == 8)
		else $error("interrupt clear count wrong");
	ts_clear_count_a: assert property (
		o_busy && o_op == opcode_timing_pkg::op_task_switched_clear
		|-> o_cycles == 5)
		else $error("task switched clear count wrong");
	third_far_count_a: assert property (
		o_busy && o_seg == opcode_timing_pkg::seg_third_extra
		|-> o_cycles inside {7, 29, 31})
		else $error("third segment far count wrong");
	stack_seg_a: assert property (
		o_busy && o_op == opcode_timing_pkg::op_far_load_stack_segment
		|-> o_seg == opcode_timing_pkg::seg_stack && o_cycles inside {7, 26, 28})
		else $error("stack far load wrong");
	carry_pulse_a: assert property (
		o_carry_clear |-> $past(o_done) && o_op == opcode_timing_pkg::op_carry_clear)
		else $error("carry clear pulse without cause");
	int_pulse_a: assert property (
		o_done && o_op == opcode_timing_pkg::op_interrupt_enable_clear
		|=> o_int_enable_clear)
		else $error("interrupt clear pulse missing");
	illegal_idle_a: assert property (
		o_illegal |-> o_byte_ready && !o_busy)
		else $error("refused byte left decoder busy");
endmodule // opcode_timing_checker

bind opcode_timing_decoder opcode_timing_checker #(.CW(CW)) u_chk (
	.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .o_byte_ready(o_byte_ready),
	.o_op(o_op), .o_seg(o_seg), .o_cycles(o_cycles), .o_busy(o_busy),
	.o_done(o_done), .o_illegal(o_illegal), .o_carry_clear(o_carry_clear),
	.o_int_enable_clear(o_int_enable_clear)
);

/* File: sim/tb.sv */
`timescale 1ns/1ps

module tb;
	logic i_ref_clk;
	logic i_rst_n;
	logic i_byte_valid;
	logic [7:0] i_byte;
	logic i_protected_mode;
	logic i_alt_timing;
	logic o_byte_ready;
	opcode_timing_pkg::op_t o_op;
	opcode_timing_pkg::seg_t o_seg;
	logic [2:0] o_reg;
	logic [1:0] o_mode;
	logic [2:0] o_rm;
	logic [4:0] o_cycles;
	logic o_busy;
	logic o_done;
	logic o_illegal;
	logic o_carry_clear;
	logic o_carry_invert;
	logic o_int_enable_clear;
	logic o_task_switched_clear;
	logic o_flags_to_acc_high;
	logic [7:0] status;
	int fail_count;
	int checks_done;

	assign status = {o_busy, o_done, o_byte_ready, o_carry_clear,
		o_carry_invert, o_int_enable_clear, o_task_switched_clear,
		o_flags_to_acc_high};

	opcode_timing_decoder dut (
		.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_byte_valid(i_byte_valid),
		.i_byte(i_byte), .i_protected_mode(i_protected_mode),
		.i_alt_timing(i_alt_timing), .o_byte_ready(o_byte_ready), .o_op(o_op),
		.o_seg(o_seg), .o_reg(o_reg), .o_mode(o_mode), .o_rm(o_rm),
		.o_cycles(o_cycles), .o_busy(o_busy), .o_done(o_done),
		.o_illegal(o_illegal), .o_carry_clear(o_carry_clear),
		.o_carry_invert(o_carry_invert), .o_int_enable_clear(o_int_enable_clear),
		.o_task_switched_clear(o_task_switched_clear),
		.o_flags_to_acc_high(o_flags_to_acc_high)
	);

	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_op(input opcode_timing_pkg::op_t got,
		input opcode_timing_pkg::op_t exp);
		chk_vec(8'(got), 8'(exp));
	endtask

	task automatic chk_seg(input opcode_timing_pkg::seg_t got,
		input opcode_timing_pkg::seg_t exp);
		chk_vec(8'(got), 8'(exp));
	endtask

	// Called at a rising edge; holds the byte until an edge sees ready high.
	task automatic send_byte(input logic [7:0] b);
		int n;
		n = 0;
		i_byte_valid <= 1'b1;
		i_byte <= b;
		do begin
			@(negedge i_ref_clk);
			n++;
		end while (o_byte_ready !== 1'b1 && n < 50);
		@(posedge i_ref_clk);
	endtask

	task automatic run_op(input logic [23:0] b, input int nb, input logic prot,
		input logic alt, input opcode_timing_pkg::op_t op,
		input opcode_timing_pkg::seg_t seg, input logic [7:0] cyc,
		input logic [4:0] flag, input logic [8:0] sel);
		@(posedge i_ref_clk);
		i_protected_mode <= prot;
		i_alt_timing <= alt;
		for (int i = nb - 1; i >= 0; i--)
			send_byte(b[i*8 +: 8]);
		i_byte_valid <= 1'b0;
		@(negedge i_ref_clk);
		chk_op(o_op, op);
		chk_seg(o_seg, seg);
		if (sel[8])
			chk_vec({o_mode, o_reg, o_rm}, sel[7:0]);
		for (int i = 0; i <= cyc; i++) begin
			chk_vec(status, i == 0 ? 8'h00 : 8'h80);
			// The count is loaded one edge after the last byte is taken.
			if (i == 1)
				chk_vec(8'(o_cycles), cyc);
			@(negedge i_ref_clk);
		end
		chk_vec(status, 8'h40);
		@(negedge i_ref_clk);
		chk_vec(status, {3'b001, flag});
	endtask

	task automatic t_flag_ops();
		logic [15:0] b [5] = '{16'h00F8, 16'h00FA, 16'h0F06, 16'h00F5, 16'h009F};
		logic [7:0] c [5] = '{8'h02, 8'h08, 8'h05, 8'h02, 8'h02};
		logic [4:0] f [5] = '{5'h10, 5'h04, 5'h02, 5'h08, 5'h01};
		opcode_timing_pkg::op_t o [5] = '{opcode_timing_pkg::op_carry_clear,
			opcode_timing_pkg::op_interrupt_enable_clear,
			opcode_timing_pkg::op_task_switched_clear,
			opcode_timing_pkg::op_carry_invert,
			opcode_timing_pkg::op_flags_to_acc_high};
		int j;
		for (int k = 0; k < 10; k++) begin
			j = k % 5;
			run_op({8'h00, b[j]}, b[j][15:8] == 8'h0F ? 2 : 1, k >= 5, 1'b0, o[j],
				opcode_timing_pkg::seg_none, c[j], f[j], 9'h000);
		end
		$display("flag ops finished");
	endtask

	task automatic t_far_loads();
		logic [15:0] b [5] = '{16'h00C5, 16'h00C4, 16'h0FB4, 16'h0FB5, 16'h0FB2};
		opcode_timing_pkg::op_t o [5] = '{
			opcode_timing_pkg::op_far_load_data_segment,
			opcode_timing_pkg::op_far_load_extra_segment,
			opcode_timing_pkg::op_far_load_third_segment,
			opcode_timing_pkg::op_far_load_fourth_segment,
			opcode_timing_pkg::op_far_load_stack_segment};
		opcode_timing_pkg::seg_t s [5] = '{opcode_timing_pkg::seg_data,
			opcode_timing_pkg::seg_extra, opcode_timing_pkg::seg_third_extra,
			opcode_timing_pkg::seg_fourth_extra, opcode_timing_pkg::seg_stack};
		logic [7:0] sel;
		logic [7:0] cyc;
		int j;
		// Real mode runs with the alternate select high: it must not matter.
		for (int k = 0; k < 15; k++) begin
			j = k % 5;
			sel = 8'(k * 37 + 3);
			cyc = (k < 5) ? 8'h07 : (j == 2) ? 8'h1D : 8'h1A;
			if (k >= 10)
				cyc = cyc + 8'h02;
			run_op({b[j], sel}, b[j][15:8] == 8'h0F ? 3 : 2, k >= 5,
				k < 5 || k >= 10, o[j], s[j], cyc, 5'h00, {1'b1, sel});
		end
		$display("far loads finished");
	endtask

	task automatic t_swap_offset();
		for (int r = 0; r < 8; r++)
			run_op({16'h0000, 5'h12, 3'(r)}, 1, r[0], 1'b0,
				opcode_timing_pkg::op_swap_operands, opcode_timing_pkg::seg_none,
				8'h03, 5'h00, {3'b100, 3'(r), 3'b000});
		run_op(24'h008DA5, 2, 1'b0, 1'b0, opcode_timing_pkg::op_load_effective_offset,
			opcode_timing_pkg::seg_none, 8'h02, 5'h00, 9'h1A5);
		run_op(24'h008DFF, 2, 1'b1, 1'b1, opcode_timing_pkg::op_load_effective_offset,
			opcode_timing_pkg::seg_none, 8'h02, 5'h00, 9'h1FF);
		$display("swap and offset finished");
	endtask

	task automatic t_illegal();
		@(posedge i_ref_clk);
		send_byte(8'hF9);
		i_byte_valid <= 1'b0;
		@(negedge i_ref_clk);
		chk_vec({5'h00, o_illegal, o_byte_ready, o_busy}, 8'h06);
		@(posedge i_ref_clk);
		send_byte(8'h0F);
		send_byte(8'h01);
		i_byte_valid <= 1'b0;
		@(negedge i_ref_clk);
		chk_vec({5'h00, o_illegal, o_byte_ready, o_busy}, 8'h06);
		@(negedge i_ref_clk);
		chk_vec({5'h00, o_illegal, o_byte_ready, o_busy}, 8'h02);
		$display("refused bytes finished");
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge i_ref_clk);
		fail_count++;
		final_report();
	end

	initial begin
		i_rst_n = 1'b0;
		i_byte_valid = 1'b0;
		i_byte = 8'h00;
		i_protected_mode = 1'b0;
		i_alt_timing = 1'b0;
		fail_count = 0;
		checks_done = 0;
		repeat (5) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
		chk_vec(status, 8'h00);
		chk_op(o_op, opcode_timing_pkg::op_none);
		@(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		t_flag_ops();
		t_far_loads();
		t_swap_offset();
		t_illegal();
		final_report();
	end
endmodule // tb
